//--- twowire_cache_defines.svh
`ifndef TWOWIRE_CACHE_DEFINES_SVH
`define TWOWIRE_CACHE_DEFINES_SVH

// Cache geometry
`define CACHE_BYTES 64
`define CACHE_IDX_W 6
`define LAST_CACHE_PAGE 3'h7
`define LAST_PAGE_BYTE 3'h7
`define ARRAY_ADDR_W 12
`define ARRAY_PAGE_W 9

// Control byte fields
`define CTRL_RW_POS 0
`define CTRL_CS_LSB 1
`define CTRL_CS_MSB 3
`define CTRL_WRITE 1'b0

// Link bit count per byte and last byte phase
`define BITS_PER_BYTE 4'h8
`define LAST_PHASE 2'h3

// Open-drain drive level
`define SDA_DRIVE_LEVEL 1'b0

// Reset values
`define LOADED_RESET 64'h0
`define STANDBY_RESET 1'b1

// Page programming time, longest time rounds down
`define PROG_TIME_US 5000
`define CLOCK_KHZ 40000
`define PROG_CYCLES_DFLT ((`PROG_TIME_US * `CLOCK_KHZ) / 1000)

`endif

//--- twowire_cache_pkg.sv
package twowire_cache_pkg;

  // Programming engine states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LOAD  = 3'b001,
    ST_SCAN  = 3'b010,
    ST_WRITE = 3'b011,
    ST_WAIT  = 3'b100
  } core_state_t;

  // Link receiver states
  typedef enum logic [1:0] {
    L_IDLE   = 2'b00,
    L_BITS   = 2'b01,
    L_ACK    = 2'b10,
    L_IGNORE = 2'b11
  } link_state_t;

  // Events passed from link to core
  typedef enum logic [1:0] {
    EV_BEGIN = 2'b00,
    EV_DATA  = 2'b01,
    EV_STOP  = 2'b10,
    EV_ABORT = 2'b11
  } event_t;

endpackage

//--- sync2.sv
`timescale 1ns/100ps
`default_nettype none

// Two-flop synchroniser, also used as reset release synchroniser
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);

  logic [WIDTH-1:0] meta_reg; // First stage, read only by o_q

  // Constants only under asynchronous reset
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_reg <= '0;
      o_q <= '0;
    end else begin
      meta_reg <= i_d;
      o_q <= meta_reg;
    end
  end

endmodule
`default_nettype wire

//--- twowire_link_rx.sv
`timescale 1ns/100ps
`default_nettype none
`include "twowire_cache_defines.svh"

// Link-side receiver: start/stop, bits, acknowledge, events
module twowire_link_rx (
  input wire logic i_link_clock,
  input wire logic i_link_rstn,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic [2:0] i_cs,
  input wire logic i_busy,
  output logic o_sda_oe,
  output logic o_sda_out,
  output logic o_active,
  output logic o_ev_toggle,
  output var twowire_cache_pkg::event_t o_ev_type,
  output logic [`ARRAY_ADDR_W-1:0] o_ev_addr,
  output logic [7:0] o_ev_data
);
  import twowire_cache_pkg::*;

  link_state_t state_reg, state_next;
  logic scl_prev_reg, sda_prev_reg; // Previous samples for edges
  logic [7:0] shift_reg, shift_next; // Incoming byte
  logic [3:0] cnt_reg, cnt_next; // Bits taken in this byte
  logic [1:0] phase_reg, phase_next; // Ctrl, addr hi, addr lo, data
  logic begun_reg, begun_next; // Write command announced
  logic oe_next, active_next, tog_next;
  event_t type_next;
  logic [`ARRAY_ADDR_W-1:0] addr_next;
  logic [7:0] data_next;
  logic scl_rise, scl_fall, start_det, stop_det, ack;

  // Next-state logic of the receiver
  always_comb begin
    scl_rise = i_scl & ~scl_prev_reg;
    scl_fall = ~i_scl & scl_prev_reg;
    // SDA moving while SCL high is only start or stop
    start_det = i_scl & scl_prev_reg & sda_prev_reg & ~i_sda;
    stop_det = i_scl & scl_prev_reg & ~sda_prev_reg & i_sda;
    state_next = state_reg;
    shift_next = shift_reg;
    cnt_next = cnt_reg;
    phase_next = phase_reg;
    begun_next = begun_reg;
    oe_next = o_sda_oe;
    tog_next = o_ev_toggle;
    type_next = o_ev_type;
    addr_next = o_ev_addr;
    data_next = o_ev_data;
    ack = 1'b0;
    if (start_det) begin
      // Restart inside a write drops the loaded data
      if (begun_reg) begin
        type_next = EV_ABORT;
        tog_next = ~o_ev_toggle;
      end
      begun_next = 1'b0;
      state_next = L_BITS;
      cnt_next = 4'h0;
      phase_next = 2'h0;
      oe_next = 1'b0;
    end else if (stop_det) begin
      if (begun_reg) begin
        type_next = EV_STOP;
        tog_next = ~o_ev_toggle;
      end
      begun_next = 1'b0;
      state_next = L_IDLE;
      oe_next = 1'b0;
    end else begin
      case (state_reg)
        L_BITS: begin
          if (scl_rise && cnt_reg != `BITS_PER_BYTE) begin
            shift_next = {shift_reg[6:0], i_sda};
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == `BITS_PER_BYTE) begin
            case (phase_reg)
              2'h0: begin
                // Select match, write only, and not programming
                ack = (shift_reg[`CTRL_CS_MSB:`CTRL_CS_LSB] == i_cs) &&
                      (shift_reg[`CTRL_RW_POS] == `CTRL_WRITE) &&
                      !i_busy;
              end
              2'h1: begin
                ack = 1'b1;
                addr_next[`ARRAY_ADDR_W-1:8] = shift_reg[3:0];
              end
              2'h2: begin
                ack = 1'b1;
                addr_next[7:0] = shift_reg;
                type_next = EV_BEGIN;
                tog_next = ~o_ev_toggle;
                begun_next = 1'b1;
              end
              default: begin
                ack = 1'b1;
                data_next = shift_reg;
                type_next = EV_DATA;
                tog_next = ~o_ev_toggle;
              end
            endcase
            // Drive starts and ends only while SCL is low
            if (ack) begin
              oe_next = 1'b1;
              state_next = L_ACK;
            end else begin
              state_next = L_IGNORE;
            end
          end
        end
        L_ACK: begin
          if (scl_fall) begin
            oe_next = 1'b0;
            cnt_next = 4'h0;
            state_next = L_BITS;
            if (phase_reg != `LAST_PHASE) begin
              phase_next = phase_reg + 2'h1;
            end
          end
        end
        default: begin
          // Idle or not addressed: wait for start or stop
          state_next = state_reg;
        end
      endcase
    end
    active_next = (state_next != L_IDLE);
  end

  // Receiver registers
  always_ff @(posedge i_link_clock or negedge i_link_rstn) begin
    if (!i_link_rstn) begin
      state_reg <= L_IDLE;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      shift_reg <= 8'h00;
      cnt_reg <= 4'h0;
      phase_reg <= 2'h0;
      begun_reg <= 1'b0;
      o_sda_oe <= 1'b0;
      o_sda_out <= `SDA_DRIVE_LEVEL;
      o_active <= 1'b0;
      o_ev_toggle <= 1'b0;
      o_ev_type <= EV_BEGIN;
      o_ev_addr <= '0;
      o_ev_data <= 8'h00;
    end else begin
      state_reg <= state_next;
      scl_prev_reg <= i_scl;
      sda_prev_reg <= i_sda;
      shift_reg <= shift_next;
      cnt_reg <= cnt_next;
      phase_reg <= phase_next;
      begun_reg <= begun_next;
      o_sda_oe <= oe_next;
      o_sda_out <= `SDA_DRIVE_LEVEL;
      o_active <= active_next;
      o_ev_toggle <= tog_next;
      o_ev_type <= type_next;
      o_ev_addr <= addr_next;
      o_ev_data <= data_next;
    end
  end

endmodule
`default_nettype wire

//--- serial_eeprom_cache_write.sv
// Operation
// - First data byte always lands in cache page 0
// - Start byte offset is address low three bits
// - Late bytes wrap into empty page 0 slots
// - Beyond 64 bytes, keep accepting and overwrite circularly
// - On stop, page 0 to addressed page, then onward
// - One timed programming cycle per transferred page
// - Program only loaded bytes of a page
// - Standby after normal stop and finished programming
// - Standby also after aborted or broken transfers
// - Low supply blocks programming; monitor off in standby
// - Answer only when select bits match pins
// - SDA driven low or released only
// - Change SDA only while SCL is low
// - SDA change with SCL high means start/stop
// - SCL from master times every bit
// - No acknowledge while programming is running
// - Each page cycle same length, at most 5 ms
// - Byte counter wrap moves to next cache line
`timescale 1ns/100ps
`default_nettype none
`include "twowire_cache_defines.svh"

module serial_eeprom_cache_write #(
  parameter int unsigned PROG_CYCLES = `PROG_CYCLES_DFLT
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_link_clock,
  input wire logic i_scl,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic [2:0] i_chip_select_pins,
  input wire logic i_supply_low,
  output logic o_array_we,
  output logic [`ARRAY_ADDR_W-1:0] o_array_addr,
  output logic [7:0] o_array_data,
  output logic o_busy,
  output logic o_standby,
  output logic o_monitor_en
);
  import twowire_cache_pkg::*;

  localparam int TW = $clog2(PROG_CYCLES + 1); // Timer width
  localparam logic [TW-1:0] PROG_LOAD = TW'(PROG_CYCLES - 1);

  // Link domain wiring
  logic link_rstn; // Reset released on the link clock
  logic [4:0] pins_s; // SCL, SDA and select pins, synchronised
  logic busy_link_s; // Busy seen on the link clock
  logic link_active; // Receiver not idle
  logic ev_toggle; // Flips once per event
  event_t ev_type; // Held stable until the next event
  logic [`ARRAY_ADDR_W-1:0] ev_addr;
  logic [7:0] ev_data;

  // Core domain wiring
  logic tog_s; // Event toggle, synchronised
  logic active_s; // Link activity, synchronised
  logic supply_low_s; // Supply warning, synchronised
  logic tog_prev_reg; // Last toggle value consumed
  logic ev_strobe; // One cycle per received event

  // Core state
  core_state_t state_reg, state_next;
  logic [7:0] cache_mem [0:`CACHE_BYTES-1]; // Write cache
  logic [`CACHE_BYTES-1:0] loaded_reg, loaded_next; // Byte loaded flags
  logic [`CACHE_IDX_W-1:0] ptr_reg, ptr_next; // Cache load pointer
  logic [`ARRAY_PAGE_W-1:0] base_reg, base_next; // Addressed array page
  logic [2:0] page_reg, page_next; // Cache page being programmed
  logic [2:0] byte_reg, byte_next; // Byte within that page
  logic [TW-1:0] timer_reg, timer_next; // Programming cycle timer
  logic we_next, busy_next, standby_next, monitor_next;
  logic [`ARRAY_ADDR_W-1:0] addr_next;
  logic [7:0] data_next;
  logic mem_we; // Cache write enable
  logic [`CACHE_IDX_W-1:0] mem_idx; // Cache write index
  logic [`CACHE_IDX_W-1:0] rd_idx; // Cache read index
  logic [7:0] page_flags; // Loaded flags of current page

  // Reset release for the link domain
  sync2 #(
    .WIDTH(1)
  ) u_link_rst (
    .i_clock(i_link_clock),
    .i_rstn(i_rstn),
    .i_d(1'b1),
    .o_q(link_rstn)
  );

  // Pins pass two flops before the receiver reads them
  sync2 #(
    .WIDTH(5)
  ) u_pin_sync (
    .i_clock(i_link_clock),
    .i_rstn(link_rstn),
    .i_d({i_scl, i_sda_in, i_chip_select_pins}),
    .o_q(pins_s)
  );

  // Busy level crosses to the link side
  sync2 #(
    .WIDTH(1)
  ) u_busy_sync (
    .i_clock(i_link_clock),
    .i_rstn(link_rstn),
    .i_d(o_busy),
    .o_q(busy_link_s)
  );

  // Receiver on the link clock
  twowire_link_rx u_rx (
    .i_link_clock(i_link_clock),
    .i_link_rstn(link_rstn),
    .i_scl(pins_s[4]),
    .i_sda(pins_s[3]),
    .i_cs(pins_s[2:0]),
    .i_busy(busy_link_s),
    .o_sda_oe(o_sda_oe),
    .o_sda_out(o_sda_out),
    .o_active(link_active),
    .o_ev_toggle(ev_toggle),
    .o_ev_type(ev_type),
    .o_ev_addr(ev_addr),
    .o_ev_data(ev_data)
  );

  // Event toggle and link activity into the core clock
  sync2 #(
    .WIDTH(2)
  ) u_core_sync (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_d({ev_toggle, link_active}),
    .o_q({tog_s, active_s})
  );

  // Supply warning pin into the core clock
  sync2 #(
    .WIDTH(1)
  ) u_supply_sync (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_d(i_supply_low),
    .o_q(supply_low_s)
  );

  // Event payload is stable for a whole byte time, so reading it
  // on the synchronised toggle edge is safe
  assign ev_strobe = tog_s ^ tog_prev_reg;
  assign rd_idx = {page_reg, byte_reg};
  assign page_flags = loaded_reg[{page_reg, 3'b000} +: 8];

  // Next-state logic of the load and programming engine
  always_comb begin
    state_next = state_reg;
    loaded_next = loaded_reg;
    ptr_next = ptr_reg;
    base_next = base_reg;
    page_next = page_reg;
    byte_next = byte_reg;
    timer_next = timer_reg;
    we_next = 1'b0;
    addr_next = o_array_addr;
    data_next = o_array_data;
    mem_we = 1'b0;
    mem_idx = ptr_reg;
    case (state_reg)
      ST_IDLE, ST_LOAD: begin
        if (ev_strobe) begin
          case (ev_type)
            EV_BEGIN: begin
              loaded_next = `LOADED_RESET;
              // Page 0, offset from address low bits
              ptr_next = {3'b000, ev_addr[2:0]};
              base_next = ev_addr[`ARRAY_ADDR_W-1:3];
              state_next = ST_LOAD;
            end
            EV_DATA: begin
              if (state_reg == ST_LOAD) begin
                mem_we = 1'b1;
                loaded_next[ptr_reg] = 1'b1;
                // Low bits wrap into next line; full wrap to page 0
                ptr_next = ptr_reg + 6'h01;
              end
            end
            EV_STOP: begin
              page_next = 3'h0;
              if (state_reg == ST_LOAD && |loaded_reg) begin
                state_next = ST_SCAN;
              end else begin
                state_next = ST_IDLE;
              end
            end
            default: begin
              // Broken transfer: drop the cache contents
              state_next = ST_IDLE;
            end
          endcase
        end
      end
      ST_SCAN: begin
        // Pages never loaded get no cycle
        byte_next = 3'h0;
        if (|page_flags) begin
          state_next = ST_WRITE;
        end else if (page_reg == `LAST_CACHE_PAGE) begin
          state_next = ST_IDLE;
        end else begin
          page_next = page_reg + 3'h1;
        end
      end
      ST_WRITE: begin
        // Only loaded bytes, and never on low supply
        if (loaded_reg[rd_idx] && !supply_low_s) begin
          we_next = 1'b1;
          addr_next = {base_reg + `ARRAY_PAGE_W'(page_reg), byte_reg};
          data_next = cache_mem[rd_idx];
        end
        if (byte_reg == `LAST_PAGE_BYTE) begin
          // Full-length cycle even for a partial page
          timer_next = PROG_LOAD;
          state_next = ST_WAIT;
        end else begin
          byte_next = byte_reg + 3'h1;
        end
      end
      ST_WAIT: begin
        if (timer_reg == '0) begin
          if (page_reg == `LAST_CACHE_PAGE) begin
            state_next = ST_IDLE;
          end else begin
            page_next = page_reg + 3'h1;
            state_next = ST_SCAN;
          end
        end else begin
          timer_next = timer_reg - TW'(1);
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // Busy covers the whole programming sequence
    busy_next = (state_next == ST_SCAN) || (state_next == ST_WRITE) ||
                (state_next == ST_WAIT);
    // Standby once both link and engine are quiet
    standby_next = (state_next == ST_IDLE) && !active_s;
    monitor_next = !standby_next;
  end

  // Cache array: no reset, contents only valid where flagged
  always_ff @(posedge i_clock) begin
    if (mem_we) begin
      cache_mem[mem_idx] <= ev_data;
    end
  end

  // Engine and output registers
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= ST_IDLE;
      tog_prev_reg <= 1'b0;
      loaded_reg <= `LOADED_RESET;
      ptr_reg <= '0;
      base_reg <= '0;
      page_reg <= 3'h0;
      byte_reg <= 3'h0;
      timer_reg <= '0;
      o_array_we <= 1'b0;
      o_array_addr <= '0;
      o_array_data <= 8'h00;
      o_busy <= 1'b0;
      o_standby <= `STANDBY_RESET;
      o_monitor_en <= ~`STANDBY_RESET;
    end else begin
      state_reg <= state_next;
      tog_prev_reg <= tog_s;
      loaded_reg <= loaded_next;
      ptr_reg <= ptr_next;
      base_reg <= base_next;
      page_reg <= page_next;
      byte_reg <= byte_next;
      timer_reg <= timer_next;
      o_array_we <= we_next;
      o_array_addr <= addr_next;
      o_array_data <= data_next;
      o_busy <= busy_next;
      o_standby <= standby_next;
      o_monitor_en <= monitor_next;
    end
  end

endmodule
`default_nettype wire

//--- cache_write_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "twowire_cache_defines.svh"
// Port-level checks for the cache write block
module cache_write_checker #(
  parameter int unsigned PROG_CYCLES = 40
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_link_clock,
  input wire logic i_scl,
  input wire logic i_supply_low,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_array_we,
  input wire logic [`ARRAY_ADDR_W-1:0] o_array_addr,
  input wire logic o_busy,
  input wire logic o_standby,
  input wire logic o_monitor_en
);
  logic [31:0] gap_reg, gap_next; // Cycles since last write, saturates
  logic [8:0] page_reg, page_next; // Page of the last write
  // Gap counter restarts on each write
  always_comb begin
    gap_next = (gap_reg == 32'hffffffff) ? gap_reg : gap_reg + 32'h1;
    page_next = page_reg;
    if (o_array_we) begin
      gap_next = 32'h0;
      page_next = o_array_addr[11:3];
    end
  end
  // Start saturated so the first page is never flagged
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      gap_reg <= 32'hffffffff;
      page_reg <= 9'h0;
    end else begin
      gap_reg <= gap_next;
      page_reg <= page_next;
    end
  end
  a_we_in_busy: assert property (@(posedge i_clock) disable iff (!i_rstn)
    o_array_we |-> o_busy) else $error("array write outside busy");
  a_low_supply_block: assert property (@(posedge i_clock)
    disable iff (!i_rstn) i_supply_low && $past(i_supply_low)
    && $past(i_supply_low, 2) && $past(i_supply_low, 3) |-> !o_array_we)
    else $error("array write under low supply");
  a_monitor_off: assert property (@(posedge i_clock) disable iff (!i_rstn)
    o_standby && $past(o_standby) |-> !o_monitor_en)
    else $error("monitor on in standby");
  a_busy_not_sby: assert property (@(posedge i_clock) disable iff (!i_rstn)
    o_busy |-> !o_standby) else $error("standby while busy");
  a_sda_low_only: assert property (@(posedge i_clock) disable iff (!i_rstn)
    o_sda_out == `SDA_DRIVE_LEVEL) else $error("sda driven high");
  a_we_ascending: assert property (@(posedge i_clock) disable iff (!i_rstn)
    o_array_we && $past(o_array_we) |-> o_array_addr ==
    $past(o_array_addr) + 12'h1) else $error("write order broken");
  a_page_wait: assert property (@(posedge i_clock) disable iff (!i_rstn)
    o_array_we && o_array_addr[11:3] != page_reg |-> gap_reg >= PROG_CYCLES)
    else $error("page cycle too short");
  a_oe_scl_low: assert property (@(posedge i_link_clock)
    disable iff (!i_rstn) $changed(o_sda_oe) |-> !i_scl)
    else $error("sda changed with scl high");
  a_no_ack_busy: assert property (@(posedge i_link_clock)
    disable iff (!i_rstn) $rose(o_sda_oe) |-> !o_busy)
    else $error("acknowledge while busy");
  a_ack_holds: assert property (@(posedge i_link_clock)
    disable iff (!i_rstn) $rose(o_sda_oe) |-> o_sda_oe [*4])
    else $error("acknowledge too short");
  c_busy: cover property (@(posedge i_clock) $rose(o_busy));
  c_write: cover property (@(posedge i_clock) o_array_we);
  c_ack: cover property (@(posedge i_link_clock) $rose(o_sda_oe));
  c_low: cover property (@(posedge i_clock) o_busy && i_supply_low);
endmodule
`default_nettype wire

//--- twowire_master_model.sv
`timescale 1ns/100ps
`default_nettype none
// Bus master: drives SCL, pulls SDA low or releases it (1)
module twowire_master_model #(
  parameter int HALF = 10
) (
  input wire logic i_clock,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  // Idle bus: both lines released
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  // Also serves as repeated start from SCL low
  task automatic start_cond();
    wait_clk(HALF);
    o_sda <= 1'b1;
    wait_clk(HALF);
    o_scl <= 1'b1;
    wait_clk(HALF);
    o_sda <= 1'b0;
    wait_clk(HALF);
    o_scl <= 1'b0;
  endtask
  task automatic stop_cond();
    o_sda <= 1'b0;
    wait_clk(HALF);
    o_scl <= 1'b1;
    wait_clk(HALF);
    o_sda <= 1'b1;
    wait_clk(HALF);
  endtask
  // SDA set only while SCL is low, sampled at end of high phase
  task automatic clock_bit(input logic b, output logic s);
    o_sda <= b;
    wait_clk(HALF);
    o_scl <= 1'b1;
    wait_clk(HALF);
    s = i_sda;
    o_scl <= 1'b0;
  endtask
  // MSB first, then release for the acknowledge bit
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(b[i], s);
    end
    clock_bit(1'b1, s);
    ack = !s;
  endtask
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int P = 40; // Short page cycle for simulation
  logic clk, lclk, rstn, supply_low, scl, m_sda, sda_wire;
  logic sda_out, sda_oe, we, busy, standby, mon_en;
  logic [2:0] pins;
  logic [11:0] waddr;
  logic [7:0] wdata;
  logic [19:0] exp_q[$]; // Expected {addr, data} writes
  int n_fail, samples_checked, busy_len, ref_len;
  int run_cnt; // Core cycles of the busy run in progress
  assign sda_wire = m_sda & !sda_oe; // Pull-up unless someone pulls
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Link clock, phase unrelated to core clock
  initial begin
    lclk = 1'b0;
    #7;
    forever #15 lclk = ~lclk;
  end
  serial_eeprom_cache_write #(.PROG_CYCLES(P)) DUT (.i_clock(clk),
    .i_rstn(rstn), .i_link_clock(lclk), .i_scl(scl), .i_sda_in(sda_wire),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_chip_select_pins(pins),
    .i_supply_low(supply_low), .o_array_we(we), .o_array_addr(waddr),
    .o_array_data(wdata), .o_busy(busy), .o_standby(standby),
    .o_monitor_en(mon_en));
  twowire_master_model M (.i_clock(clk), .i_sda(sda_wire), .o_scl(scl),
    .o_sda(m_sda));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task results();
    $display("checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Whole busy run length, taken when busy falls; independent of
  // where the stimulus happens to start waiting
  always @(posedge clk) begin
    if (busy === 1'b1) begin
      run_cnt <= run_cnt + 1;
    end else if (run_cnt != 0) begin
      busy_len <= run_cnt;
      run_cnt <= 0;
    end
  end
  // Each array write takes the oldest note
  always @(posedge clk) begin
    if (we === 1'b1) begin
      if (exp_q.size() == 0) chk(32'h1, 32'h0);
      else chk({waddr, wdata}, exp_q.pop_front());
    end
  end
  // One write command; cache model fills the expectation queue
  task automatic write_cmd(input logic [2:0] cs, input logic [11:0] a,
    input int n, input bit abort);
    logic ack, hit;
    logic [7:0] cache[64];
    bit ld[64];
    int k;
    hit = (cs == pins);
    M.start_cond();
    M.send_byte({4'ha, cs, 1'b0}, ack);
    chk(ack, hit);
    M.send_byte({4'h0, a[11:8]}, ack);
    chk(ack, hit);
    M.send_byte(a[7:0], ack);
    chk(ack, hit);
    for (int i = 0; i < 64; i++) ld[i] = 1'b0;
    for (int i = 0; i < n; i++) begin
      k = (a[2:0] + i) % 64;
      cache[k] = 8'($urandom);
      ld[k] = 1'b1;
      M.send_byte(cache[k], ack);
      chk(ack, hit);
    end
    // Notes go in before the stop, as writes follow it quickly
    if (hit && !abort && !supply_low) begin
      for (int i = 0; i < 64; i++) begin
        if (ld[i]) exp_q.push_back({a[11:3] + 9'(i / 8), 3'(i), cache[i]});
      end
    end
    if (abort) M.start_cond();
    M.stop_cond();
  endtask
  // Control byte only; acknowledge tells busy from idle
  task automatic poll(input logic exp);
    logic ack;
    M.start_cond();
    M.send_byte({4'ha, pins, 1'b0}, ack);
    chk(ack, exp);
    M.stop_cond();
  endtask
  // Bounded wait for programming, then idle state checks
  task automatic wait_done(input bit prog);
    int k, t;
    k = 0;
    t = 0;
    while (prog && busy !== 1'b1 && k < 100) begin
      @(posedge clk);
      k++;
    end
    // Programming keeps the block awake
    if (busy === 1'b1) begin
      chk(standby, 1'b0);
      chk(mon_en, 1'b1);
    end
    while (prog && busy === 1'b1 && t < 20000) begin
      @(posedge clk);
      t++;
    end
    // A used-up bound is a failure by itself
    if (k == 100 || t == 20000) begin
      n_fail++;
      chk(busy, prog);
      results();
    end
    repeat (20) @(posedge clk);
    chk(standby, 1'b1);
    chk(mon_en, 1'b0);
    chk(exp_q.size(), 0);
  endtask
  initial begin
    rstn = 1'b0;
    supply_low = 1'b0;
    pins = 3'h5;
    n_fail = 0;
    samples_checked = 0;
    void'($urandom(61));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (10) @(posedge clk);
    write_cmd(pins, {9'($urandom), 3'h2}, 64, 0);
    poll(1'b0);
    wait_done(1);
    $display("wrap test done");
    write_cmd(pins, {9'($urandom), 3'h5}, 70, 0);
    wait_done(1);
    $display("overwrite test done");
    write_cmd(pins, 12'hffe, 5, 0);
    wait_done(1);
    ref_len = busy_len;
    chk(busy_len <= 2 * (P + 20), 1'b1);
    $display("partial test done");
    supply_low <= 1'b1;
    write_cmd(pins, 12'hffe, 5, 0);
    wait_done(1);
    chk(busy_len, ref_len);
    supply_low <= 1'b0;
    $display("low supply test done");
    for (int c = 0; c < 8; c++) begin
      write_cmd(3'(c), 12'($urandom), 1, 0);
      wait_done(3'(c) == pins);
    end
    $display("select test done");
    write_cmd(pins, 12'h123, 3, 1);
    wait_done(0);
    poll(1'b1);
    wait_done(0);
    $display("abort test done");
    results();
  end
endmodule
bind serial_eeprom_cache_write cache_write_checker #(
  .PROG_CYCLES(PROG_CYCLES)) u_chk (.i_clock(i_clock), .i_rstn(i_rstn),
  .i_link_clock(i_link_clock), .i_scl(i_scl), .i_supply_low(i_supply_low),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_array_we(o_array_we),
  .o_array_addr(o_array_addr), .o_busy(o_busy), .o_standby(o_standby),
  .o_monitor_en(o_monitor_en));
`default_nettype wire
